// ===== verilog/disable_group_ctrl.sv
// Output-disable group controller for a multi-channel PWM timer
`timescale 1ns/100ps
`include "odc_map.svh"
module disable_group_ctrl
  import odc_pkg::*;
#(
  parameter int NG       = `ODC_NUM_GROUPS,
  parameter int NC       = `ODC_NUM_CHANNELS,
  parameter int STOP_CYC = `ODC_OSC_STOP_CYC
) (
  input  wire logic                   CLK,
  input  wire logic                   NRST,
  input  wire logic                   CE,
  input  wire logic [NG-1:0]          EXTERNAL_TRIGGER_INPUT,
  input  wire logic [2*NG-1:0]        TRIG_MODE,
  input  wire logic [NG-1:0]          PIN_DETECT_ENABLE,
  input  wire logic [NG-1:0]          TIMER_REQUEST_ENABLE,
  input  wire logic [NG-1:0]          OSC_STOP_ENABLE,
  input  wire logic [NG-1:0]          SOFTWARE_FORCE_DISABLE,
  input  wire logic [NG-1:0]          PIN_DETECT_CLEAR,
  input  wire logic [NG-1:0]          TIMER_REQUEST_CLEAR,
  input  wire logic [NG-1:0]          OSC_STOP_CLEAR,
  input  wire logic                   OSC_TICK,
  input  wire logic [NC-1:0]          CHANNEL_DISABLE_REQUEST,
  input  wire logic [NC-1:0]          SHORT_DETECT_HIGH_ENABLE,
  input  wire logic [NC-1:0]          SHORT_DETECT_LOW_ENABLE,
  input  wire logic [NC-1:0]          SHORT_HIGH,
  input  wire logic [NC-1:0]          SHORT_LOW,
  input  wire logic [2*NC-1:0]        GROUP_SELECT,
  input  wire logic [2*NC-1:0]        OUTPUT_A_DISABLE_VALUE,
  input  wire logic [2*NC-1:0]        OUTPUT_B_DISABLE_VALUE,
  input  wire logic [1:0]             THREE_PHASE_GROUP_SELECT,
  input  wire logic                   THREE_PHASE_DISABLE_ENABLE,
  input  wire logic                   THREE_PHASE_SHORT,
  output logic      [NG-1:0]          PIN_DETECT_FLAG,
  output logic      [NG-1:0]          TIMER_REQUEST_FLAG,
  output logic      [NG-1:0]          OSC_STOP_FLAG,
  output logic      [NG-1:0]          GROUP_DISABLE,
  output logic      [NC-1:0]          CHANNEL_A_DISABLE,
  output logic      [NC-1:0]          CHANNEL_B_DISABLE,
  output logic      [2*NC-1:0]        CHANNEL_A_VALUE,
  output logic      [2*NC-1:0]        CHANNEL_B_VALUE,
  output logic                        THREE_PHASE_DISABLE
);
  logic          halted;
  logic [NG-1:0] trig_last;
  logic [NG-1:0] pin_hit;
  logic [NG-1:0] req_hit;
  logic [NG-1:0] active;

  odc_osc_watch #(
    .STOP_CYC (STOP_CYC)
  ) u_osc_watch (
    .CLK      (CLK),
    .NRST     (NRST),
    .CE       (CE),
    .osc_tick (OSC_TICK),
    .halted   (halted)
  );

  // Previous trigger level for edge detection
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      trig_last <= '0;
    end else if (CE) begin
      trig_last <= EXTERNAL_TRIGGER_INPUT;
    end
  end

  // Per-group source detection
  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : g_grp
      logic       t;
      logic       p;
      trig_mode_t m;
      assign t = EXTERNAL_TRIGGER_INPUT[g];
      assign p = trig_last[g];
      assign m = TRIG_MODE[2*g +: 2];
      // Configured level or edge of the trigger pin
      always_comb begin
        unique case (m)
          `ODC_TRIG_LEVEL: pin_hit[g] = ~t;
          `ODC_TRIG_RISE:  pin_hit[g] = t & ~p;
          `ODC_TRIG_FALL:  pin_hit[g] = ~t & p;
          `ODC_TRIG_BOTH:  pin_hit[g] = t ^ p;
        endcase
      end
      // Requests from channels routed to this group
      always_comb begin
        req_hit[g] = 1'b0;
        for (int c = 0; c < NC; c++) begin
          if (GROUP_SELECT[2*c +: 2] == 2'(g)) begin
            if (CHANNEL_DISABLE_REQUEST[c]) begin
              req_hit[g] = 1'b1;
            end
            if (SHORT_DETECT_HIGH_ENABLE[c] && SHORT_HIGH[c]) begin
              req_hit[g] = 1'b1;
            end
            if (SHORT_DETECT_LOW_ENABLE[c] && SHORT_LOW[c]) begin
              req_hit[g] = 1'b1;
            end
          end
        end
        if (THREE_PHASE_GROUP_SELECT == 2'(g) && THREE_PHASE_SHORT) begin
          req_hit[g] = 1'b1;
        end
      end
    end
  endgenerate

  // Pin-detect flags; set wins over clear, held while cause stays
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      PIN_DETECT_FLAG <= '0;
    end else if (CE) begin
      PIN_DETECT_FLAG <= (PIN_DETECT_FLAG
                          & ~(PIN_DETECT_CLEAR & ~pin_hit))
                         | (PIN_DETECT_ENABLE & pin_hit);
    end
  end

  // Timer-request flags
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      TIMER_REQUEST_FLAG <= '0;
    end else if (CE) begin
      TIMER_REQUEST_FLAG <= (TIMER_REQUEST_FLAG
                             & ~(TIMER_REQUEST_CLEAR & ~req_hit))
                            | (TIMER_REQUEST_ENABLE & req_hit);
    end
  end

  // Oscillator-stop flags
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      OSC_STOP_FLAG <= '0;
    end else if (CE) begin
      OSC_STOP_FLAG <= (OSC_STOP_FLAG
                        & ~(OSC_STOP_CLEAR & ~{NG{halted}}))
                       | (OSC_STOP_ENABLE & {NG{halted}});
    end
  end

  // Group disable condition from any source
  assign active = PIN_DETECT_FLAG | TIMER_REQUEST_FLAG | OSC_STOP_FLAG
                  | SOFTWARE_FORCE_DISABLE;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      GROUP_DISABLE <= '0;
    end else if (CE) begin
      GROUP_DISABLE <= active;
    end
  end

  // Per-channel disable condition; pins driven in timer logic
  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_ch
      grp_sel_t gs;
      dis_val_t va;
      dis_val_t vb;
      assign gs = GROUP_SELECT[2*c +: 2];
      assign va = OUTPUT_A_DISABLE_VALUE[2*c +: 2];
      assign vb = OUTPUT_B_DISABLE_VALUE[2*c +: 2];
      always_ff @(posedge CLK) begin
        if (!NRST) begin
          CHANNEL_A_DISABLE[c]     <= 1'b0;
          CHANNEL_B_DISABLE[c]     <= 1'b0;
          CHANNEL_A_VALUE[2*c +: 2] <= `ODC_DV_NONE;
          CHANNEL_B_VALUE[2*c +: 2] <= `ODC_DV_NONE;
        end else if (CE) begin
          CHANNEL_A_DISABLE[c] <= active[gs]
                                  && (va != `ODC_DV_NONE);
          CHANNEL_B_DISABLE[c] <= active[gs]
                                  && (vb != `ODC_DV_NONE);
          CHANNEL_A_VALUE[2*c +: 2] <= va;
          CHANNEL_B_VALUE[2*c +: 2] <= vb;
        end
      end
    end
  endgenerate

  // Three-phase motor outputs follow their chosen group
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      THREE_PHASE_DISABLE <= 1'b0;
    end else if (CE) begin
      THREE_PHASE_DISABLE <= THREE_PHASE_DISABLE_ENABLE
                             && active[THREE_PHASE_GROUP_SELECT];
    end
  end
endmodule // disable_group_ctrl

// ===== verilog/odc_map.svh
// Constants of the output-disable group controller
`ifndef ODC_MAP_SVH
`define ODC_MAP_SVH
`define ODC_NUM_GROUPS   4
`define ODC_NUM_CHANNELS 4
`define ODC_GRP_W        2
`define ODC_DV_W         2
`define ODC_DV_NONE      2'h0
`define ODC_DV_HIZ       2'h1
`define ODC_DV_LOW       2'h2
`define ODC_DV_HIGH      2'h3
`define ODC_OSC_STOP_NS  1000
`define ODC_CLK_NS       10
`define ODC_OSC_STOP_CYC ((`ODC_OSC_STOP_NS) / (`ODC_CLK_NS))
`define ODC_TRIG_LEVEL   2'h0
`define ODC_TRIG_RISE    2'h1
`define ODC_TRIG_FALL    2'h2
`define ODC_TRIG_BOTH    2'h3
`endif

// ===== verilog/odc_pkg.sv
// Types of the output-disable group controller
package odc_pkg;
  typedef logic [1:0] trig_mode_t;
  typedef logic [1:0] grp_sel_t;
  typedef logic [1:0] dis_val_t;
endpackage

// ===== verilog/odc_osc_watch.sv
// Watchdog that flags a halted main oscillator
`timescale 1ns/100ps
`include "odc_map.svh"
module odc_osc_watch
  import odc_pkg::*;
#(
  parameter int STOP_CYC = `ODC_OSC_STOP_CYC
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic CE,
  input  wire logic osc_tick,
  output logic      halted
);
  logic [15:0] idle_count;
  logic        last_tick;

  // Count cycles since the oscillator tick last toggled
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      idle_count <= 16'h0000;
      last_tick  <= 1'b0;
      halted     <= 1'b0;
    end else if (CE) begin
      last_tick <= osc_tick;
      if (osc_tick != last_tick) begin
        idle_count <= 16'h0000;
        halted     <= 1'b0;
      end else if (idle_count >= 16'(STOP_CYC - 1)) begin
        halted <= 1'b1;
      end else begin
        idle_count <= idle_count + 16'h0001;
      end
    end
  end
endmodule // odc_osc_watch

// ===== test/odc_sva.sv
// Assertion checker for the output-disable group controller
`timescale 1ns/100ps
module odc_sva #(
  parameter int NG = 4,
  parameter int NC = 4
) (
  input wire logic            CLK,
  input wire logic            NRST,
  input wire logic            CE,
  input wire logic [NG-1:0]   PIN_DETECT_ENABLE,
  input wire logic [NG-1:0]   TIMER_REQUEST_ENABLE,
  input wire logic [NG-1:0]   SOFTWARE_FORCE_DISABLE,
  input wire logic [NG-1:0]   PIN_DETECT_CLEAR,
  input wire logic [2*NC-1:0] OUTPUT_A_DISABLE_VALUE,
  input wire logic            THREE_PHASE_DISABLE_ENABLE,
  input wire logic [NG-1:0]   PIN_DETECT_FLAG,
  input wire logic [NG-1:0]   TIMER_REQUEST_FLAG,
  input wire logic [NG-1:0]   OSC_STOP_FLAG,
  input wire logic [NG-1:0]   GROUP_DISABLE,
  input wire logic [NC-1:0]   CHANNEL_A_DISABLE,
  input wire logic            THREE_PHASE_DISABLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Group 0 sources against its flags and disable output, then channel 0 A and three-phase disable gating
  AST_SOFT: assert property (CE && SOFTWARE_FORCE_DISABLE[0]
    |=> GROUP_DISABLE[0]) else $error("force ignored");
  AST_FOLLOW: assert property (CE && PIN_DETECT_FLAG[0]
    |=> GROUP_DISABLE[0]) else $error("flag not followed");
  AST_IDLE: assert property (CE && !(PIN_DETECT_FLAG[0]
    || TIMER_REQUEST_FLAG[0] || OSC_STOP_FLAG[0]
    || SOFTWARE_FORCE_DISABLE[0]) |=> !GROUP_DISABLE[0])
    else $error("disable without cause");
  AST_HOLD: assert property (PIN_DETECT_FLAG[0]
    && !PIN_DETECT_CLEAR[0] |=> PIN_DETECT_FLAG[0])
    else $error("flag lost");
  AST_PIN_OFF: assert property (CE && !PIN_DETECT_ENABLE[0]
    && !PIN_DETECT_FLAG[0] |=> !PIN_DETECT_FLAG[0])
    else $error("pin flag while off");
  AST_TR_OFF: assert property (CE && !TIMER_REQUEST_ENABLE[0]
    && !TIMER_REQUEST_FLAG[0] |=> !TIMER_REQUEST_FLAG[0])
    else $error("request flag while off");
  AST_A_NONE: assert property (CE
    && OUTPUT_A_DISABLE_VALUE[1:0] == 2'h0 |=> !CHANNEL_A_DISABLE[0])
    else $error("pin disabled with value none");
  AST_TP_OFF: assert property (CE && !THREE_PHASE_DISABLE_ENABLE
    |=> !THREE_PHASE_DISABLE) else $error("motor disabled while off");
  // Main scenarios reached
  cover property (GROUP_DISABLE[0]);
  cover property (CHANNEL_A_DISABLE[0]);
  cover property (THREE_PHASE_DISABLE);
  cover property (OSC_STOP_FLAG[0]);
endmodule // odc_sva

bind disable_group_ctrl odc_sva #(.NG(NG), .NC(NC)) odc_sva_i (.*);

// ===== test/timer_side_model.sv
// Timer-side model: oscillator tick and gated channel requests
`timescale 1ns/100ps
module timer_side_model (
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic       run,
  input  wire logic [3:0] req,
  input  wire logic [3:0] en,
  output logic            tick,
  output logic [3:0]      chan_req
);
  // Tick toggles only while the oscillator runs
  always_ff @(posedge CLK) tick <= NRST && (tick ^ run);
  assign chan_req = req & en;
endmodule // timer_side_model

// ===== test/disable_group_ctrl_tb.sv
// Self-checking bench for the output-disable group controller
`timescale 1ns/100ps
module disable_group_ctrl_tb;
  logic        CLK = 0, NRST = 0, CE = 1, run = 0, tpe = 0, tps = 0;
  logic        mtp = 0, tick, tp;
  logic [1:0]  tpg = '0;
  logic [3:0]  ext = '0, pde = '0, tre = '0, ose = '0, sfd = '0, pdc = '0;
  logic [3:0]  trc = '0, oc = '0, she = '0, sle = '0, shi = '0, slo = '0;
  logic [3:0]  req = '0, en = '0, mpf = '0, mtf = '0, mgd = '0, prev = '0;
  logic [3:0]  mca = '0, mcb = '0, cdr, pf, tf, of, gd, ca, cb;
  logic [7:0]  tm = '0, gs = '0, av = '0, bv = '0;
  logic [7:0]  cav, cbv, mav = '0, mbv = '0;
  logic [36:0] dut_out, ref_out;
  logic [95:0] rv;
  int          failures = 0, checks_done = 0;

  always #5 CLK = !CLK;
  timer_side_model timer_side_model_i (.CLK(CLK), .NRST(NRST), .run(run),
    .req(req), .en(en), .tick(tick), .chan_req(cdr));
  disable_group_ctrl #(.STOP_CYC(8)) disable_group_ctrl_i (.CLK(CLK),
    .NRST(NRST), .CE(CE), .EXTERNAL_TRIGGER_INPUT(ext), .TRIG_MODE(tm),
    .PIN_DETECT_ENABLE(pde), .TIMER_REQUEST_ENABLE(tre),
    .OSC_STOP_ENABLE(ose), .SOFTWARE_FORCE_DISABLE(sfd),
    .PIN_DETECT_CLEAR(pdc), .TIMER_REQUEST_CLEAR(trc), .OSC_STOP_CLEAR(oc),
    .OSC_TICK(tick), .CHANNEL_DISABLE_REQUEST(cdr),
    .SHORT_DETECT_HIGH_ENABLE(she), .SHORT_DETECT_LOW_ENABLE(sle),
    .SHORT_HIGH(shi), .SHORT_LOW(slo), .GROUP_SELECT(gs),
    .OUTPUT_A_DISABLE_VALUE(av), .OUTPUT_B_DISABLE_VALUE(bv),
    .THREE_PHASE_GROUP_SELECT(tpg), .THREE_PHASE_DISABLE_ENABLE(tpe),
    .THREE_PHASE_SHORT(tps), .PIN_DETECT_FLAG(pf), .TIMER_REQUEST_FLAG(tf),
    .OSC_STOP_FLAG(of), .GROUP_DISABLE(gd), .CHANNEL_A_DISABLE(ca),
    .CHANNEL_B_DISABLE(cb), .CHANNEL_A_VALUE(cav), .CHANNEL_B_VALUE(cbv),
    .THREE_PHASE_DISABLE(tp));

  // Every registered output except the oscillator-stop flags against its model value
  assign dut_out = {pf, tf, gd, ca, cb, tp, cav, cbv};
  assign ref_out = {mpf, mtf, mgd, mca, mcb, mtp, mav, mbv};

  // Compare one result and count it
  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t outputs %h expected %h", $time, got, exp);
    end
  endtask

  // Advance the reference model by one enabled clock
  task automatic step;
    logic [3:0] npf, ntf;
    logic       d;
    for (int g = 0; g < 4; g++) begin
      case (tm[2*g+:2])
        2'h0: d = !ext[g];
        2'h1: d = ext[g] && !prev[g];
        2'h2: d = !ext[g] && prev[g];
        default: d = ext[g] != prev[g];
      endcase
      npf[g] = pde[g] && d || mpf[g] && !(pdc[g] && !d);
      d = tps && tpg == g;
      for (int c = 0; c < 4; c++)
        if (gs[2*c+:2] == g && (cdr[c] || she[c] && shi[c]
            || sle[c] && slo[c])) d = 1;
      ntf[g] = tre[g] && d || mtf[g] && !(trc[g] && !d);
      mgd[g] = mpf[g] || mtf[g] || sfd[g];
    end
    for (int c = 0; c < 4; c++) begin
      mca[c] = mgd[gs[2*c+:2]] && av[2*c+:2] != 2'h0;
      mcb[c] = mgd[gs[2*c+:2]] && bv[2*c+:2] != 2'h0;
    end
    mtp = tpe && mgd[tpg];
    {mav, mbv} = {av, bv};
    {mpf, mtf, prev} = {npf, ntf, ext};
  endtask

  // Print the verdict and stop
  task automatic results;
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Reset, random traffic against the model, then oscillator stop
  initial begin
    void'($urandom(32'h374ad5f0));
    repeat (16) @(negedge CLK);
    NRST = 1;
    run = 1;
    repeat (400) @(negedge CLK) begin
      chk(dut_out, ref_out);
      rv = {$urandom, $urandom, $urandom};
      {ext, tm, pde, tre, sfd, she, sle, shi, slo, gs, av, bv, tpg, tpe,
        tps, req, en} = rv[75:0];
      pdc = 4'($urandom & $urandom & $urandom);
      trc = 4'($urandom & $urandom & $urandom);
      CE = |3'($urandom);
      #1 if (CE) step;
    end
    {pde, tre, sfd, she, sle, tpe, tps, req, CE, pdc, trc} = {26'h0, 9'h1ff};
    // High pins in low-level mode leave no cause, so the clears take
    {ext, tm} = {4'hf, 8'h00};
    ose = 4'h5;
    run = 0;
    repeat (12) @(negedge CLK);
    chk(37'({of, gd}), 37'h55);
    run = 1;
    oc = 4'hf;
    repeat (12) @(negedge CLK);
    chk(37'({of, gd}), 37'h0);
    // Mid-run reset clears every output
    NRST = 0;
    @(negedge CLK);
    chk(dut_out, 37'h0);
    results;
  end

  // Watchdog against a hang
  initial begin
    #10000;
    failures++;
    results;
  end
endmodule // disable_group_ctrl_tb
